// file: rtl/pdr_port_data_regs.sv
`timescale 1ns/1ns
`include "pdr_cfg.svh"

module pdr_port_data_regs (
    input wire logic clock, // Common clock, also clocks the cells.
    input wire logic rst, // Synchronous reset, active high.
    input wire pdr_pkg::pdr_bus_req_t busReq, // Microcontroller cycle.
    output logic [7:0] rdData, // Read data, valid after a read.
    input wire logic [6:0][7:0] pinIn, // Pin levels, ports A to G.
    output pdr_pkg::pdr_pin_drive_t [6:0] pinDrive, // Pin drive.
    input wire logic [3:0][7:0] logicOeTerm, // OE terms A,B,C,F.
    input wire logic [1:0][7:0] cellNext, // Cell inputs A,B.
    input wire logic [7:0] externalChipSelects, // Chip selects.
    input wire logic [7:0] addrLow, // Low address byte.
    input wire logic vccBelowBat, // Supply below battery.
    input wire logic [7:0] scanOut, // Boundary-scan pin data.
    input wire logic [7:0] scanOe, // Boundary-scan pin enables.
    output logic [1:0][7:0] cellOut, // Output cells A,B.
    output logic [2:0][7:0] inCellOut, // Input cells A,B,C.
    output logic [3:0] portdDirect, // Port D to logic array.
    output logic [7:0] portfDirect, // Port F to logic array.
    output logic [1:0][7:0] fastSlew, // Slew select C,F.
    output logic memEnable // Memories and registers selected.
);

    logic [6:0][7:0] sync1, sync2, sync3, pinLvl_q;
    logic [6:0][7:0] outLatch_q, dir_q, drive_q, ctrl_q, route_q;
    logic [1:0][7:0] mask_q;
    logic [7:0] mode_q, addrLat_q, rdData_q;
    logic rdLast_q, memEnable_q;
    logic [6:0][7:0] effOut, effEn;
    pdr_pkg::pdr_pin_drive_t [6:0] drive_q2;
    logic [3:0] regType;
    logic [2:0] portIdx;
    logic csiOk, strobe, exists, wrHit, rdHit;
    logic [7:0] wMask, rdVal;

    // Three-stage pin synchroniser; a bit moves only once the second and
    // third stages agree, so a single metastable sample cannot be seen.
    genvar p;
    generate
        for (p = 0; p < `PDR_NPORT; p++) begin : gSync
            always_ff @(posedge clock) begin
                if (rst) begin
                    sync1[p] <= `PDR_REG_RESET;
                    sync2[p] <= `PDR_REG_RESET;
                    sync3[p] <= `PDR_REG_RESET;
                    pinLvl_q[p] <= `PDR_REG_RESET;
                end else begin
                    sync1[p] <= pinIn[p];
                    sync2[p] <= sync1[p];
                    sync3[p] <= sync2[p];
                    pinLvl_q[p] <= (sync3[p] & ~(sync2[p] ^ sync3[p])) |
                        (pinLvl_q[p] & (sync2[p] ^ sync3[p]));
                end
            end
        end
    endgenerate

    // Port D bit 0 is the address strobe, bit 2 the low chip select.
    assign strobe = pinLvl_q[3][0];
    assign csiOk = ~(mode_q[`PDR_M_CSI_EN] & pinLvl_q[3][2]);
    assign regType = busReq.addr[7:4];
    assign portIdx = busReq.addr[2:0];

    // Decode which type and port pairs really exist.
    always_comb begin
        exists = 1'b0;
        if (busReq.addr[3] == 1'b0 && portIdx != 3'h7) begin
            case (regType)
                `PDR_T_PIN_LEVEL, `PDR_T_OUT_LATCH, `PDR_T_DIRECTION,
                `PDR_T_DRIVE_SEL: begin
                    exists = 1'b1;
                end
                `PDR_T_CONTROL: begin
                    exists = portIdx >= `PDR_PE;
                end
                `PDR_T_OUT_CELLS, `PDR_T_CELL_MASK: begin
                    exists = portIdx <= `PDR_PB;
                end
                `PDR_T_IN_CELLS: begin
                    exists = portIdx <= `PDR_PC;
                end
                `PDR_T_DRV_STATUS, `PDR_T_ALT_ROUTE: begin
                    exists = portIdx <= `PDR_PC ||
                        portIdx == `PDR_PF;
                end
                `PDR_T_MODE: begin
                    exists = portIdx == `PDR_PA;
                end
                default: begin
                    exists = 1'b0;
                end
            endcase
        end
    end

    // Each access is one plain strobe; nothing is sequenced.
    assign wrHit = busReq.sel & busReq.wr & csiOk & exists;
    assign rdHit = busReq.sel & busReq.rd & csiOk & exists;
    assign wMask = (portIdx == `PDR_PD) ? `PDR_PORTD_MASK : 8'hFF;

    // Writable port registers; all start cleared, so every pin not enabled by logicOeTerm is an input.
    always_ff @(posedge clock) begin
        if (rst) begin
            outLatch_q <= '0;
            dir_q <= '0;
            drive_q <= '0;
            ctrl_q <= '0;
            route_q <= '0;
            mode_q <= `PDR_REG_RESET;
        end else if (wrHit) begin
            case (regType)
                `PDR_T_OUT_LATCH: begin
                    outLatch_q[portIdx] <= busReq.wdata & wMask;
                end
                `PDR_T_DIRECTION: begin
                    dir_q[portIdx] <= busReq.wdata & wMask;
                end
                `PDR_T_DRIVE_SEL: begin
                    drive_q[portIdx] <= busReq.wdata & wMask;
                end
                `PDR_T_CONTROL: begin
                    ctrl_q[portIdx] <= busReq.wdata;
                end
                `PDR_T_ALT_ROUTE: begin
                    route_q[portIdx] <= busReq.wdata;
                end
                `PDR_T_MODE: begin
                    mode_q <= busReq.wdata;
                end
                default: begin
                    mode_q <= mode_q;
                end
            endcase
        end
    end

    // Mask registers for the two cell groups.
    always_ff @(posedge clock) begin
        if (rst) begin
            mask_q <= '0;
        end else if (wrHit && regType == `PDR_T_CELL_MASK) begin
            mask_q[portIdx[0]] <= busReq.wdata;
        end
    end

    // Output cells follow the logic array each clock; a bus write overrides
    // only the unmasked bits, so masked cells keep running their equations.
    generate
        for (p = 0; p < 2; p++) begin : gCell
            always_ff @(posedge clock) begin
                if (rst) begin
                    cellOut[p] <= `PDR_REG_RESET;
                end else if (wrHit && regType == `PDR_T_OUT_CELLS &&
                        portIdx == 3'(p)) begin
                    cellOut[p] <= (busReq.wdata & ~mask_q[p]) |
                        (cellNext[p] & mask_q[p]);
                end else begin
                    cellOut[p] <= cellNext[p];
                end
            end
        end
    endgenerate

    // Input cells and the address latch are transparent while the strobe
    // is high and hold once it falls.
    always_ff @(posedge clock) begin
        if (rst) begin
            inCellOut <= '0;
            addrLat_q <= `PDR_REG_RESET;
        end else if (strobe) begin
            inCellOut <= pinLvl_q[2:0];
            addrLat_q <= addrLow;
        end
    end

    // Direct inputs to the logic array bypass any latching.
    always_ff @(posedge clock) begin
        if (rst) begin
            portdDirect <= 4'h0;
            portfDirect <= `PDR_REG_RESET;
            fastSlew <= '0;
            memEnable_q <= 1'b0;
        end else begin
            portdDirect <= pinLvl_q[3][3:0];
            portfDirect <= pinLvl_q[5];
            fastSlew[0] <= drive_q[2];
            fastSlew[1] <= drive_q[5];
            memEnable_q <= csiOk;
        end
    end
    assign memEnable = memEnable_q;

    // Pin source and enable for each port, before open-drain shaping.
    always_comb begin
        effOut = outLatch_q;
        effEn = dir_q;
        for (int i = 0; i < 3; i++) begin
            effEn[i] = dir_q[i] | logicOeTerm[i];
        end
        effEn[5] = dir_q[5] | logicOeTerm[3];
        effOut[0] = (route_q[0] & cellOut[0]) |
            (~route_q[0] & outLatch_q[0]);
        effOut[1] = (route_q[1] & cellOut[1]) |
            (~route_q[1] & outLatch_q[1]);
        effOut[2] = (route_q[2] & externalChipSelects) |
            (~route_q[2] & outLatch_q[2]);
        effOut[5] = (route_q[5] & externalChipSelects) |
            (~route_q[5] & outLatch_q[5]);
        for (int i = 4; i < 7; i++) begin
            effOut[i] = (ctrl_q[i] & addrLat_q) |
                (~ctrl_q[i] & effOut[i]);
        end
        if (mode_q[`PDR_M_BAT_IND]) begin
            effOut[4][7] = vccBelowBat;
            effEn[4][7] = 1'b1;
        end
        if (mode_q[`PDR_M_BAT_IN]) begin
            effEn[4][6] = 1'b0;
        end
        if (mode_q[`PDR_M_SCAN_EN]) begin
            effOut[4] = scanOut;
            effEn[4] = scanOe;
        end
        if (mode_q[`PDR_M_DATA_PORT]) begin
            effOut[5] = rdData_q;
            effEn[5] = {8{rdLast_q}};
        end
        effEn[3][7:4] = 4'h0;
    end

    // Registered pin drive; open-drain pins release instead of driving one.
    generate
        for (p = 0; p < `PDR_NPORT; p++) begin : gDrive
            always_ff @(posedge clock) begin
                if (rst) begin
                    drive_q2[p] <= '0;
                end else if (p == 2 || p == 5) begin
                    drive_q2[p].out <= effOut[p];
                    drive_q2[p].oe <= effEn[p];
                end else begin
                    drive_q2[p].out <= effOut[p];
                    drive_q2[p].oe <= effEn[p] &
                        ~(drive_q[p] & effOut[p]);
                end
            end
        end
    endgenerate
    assign pinDrive = drive_q2;

    // Read multiplexer; unmapped or deselected reads return zero.
    always_comb begin
        rdVal = `PDR_UNMAPPED;
        case (regType)
            `PDR_T_PIN_LEVEL: rdVal = pinLvl_q[portIdx] & wMask;
            `PDR_T_OUT_LATCH: rdVal = outLatch_q[portIdx];
            `PDR_T_DIRECTION: rdVal = dir_q[portIdx];
            `PDR_T_DRIVE_SEL: rdVal = drive_q[portIdx];
            `PDR_T_CONTROL: rdVal = ctrl_q[portIdx];
            `PDR_T_OUT_CELLS: rdVal = cellOut[portIdx[0]];
            `PDR_T_CELL_MASK: rdVal = mask_q[portIdx[0]];
            `PDR_T_IN_CELLS: rdVal = inCellOut[portIdx[1:0]];
            `PDR_T_DRV_STATUS: rdVal = effEn[portIdx];
            `PDR_T_ALT_ROUTE: rdVal = route_q[portIdx];
            `PDR_T_MODE: rdVal = mode_q;
            default: rdVal = `PDR_UNMAPPED;
        endcase
    end

    // Read data is captured on every selected bus read and held until the next read.
    always_ff @(posedge clock) begin
        if (rst) begin
            rdData_q <= `PDR_UNMAPPED;
            rdLast_q <= 1'b0;
        end else begin
            rdLast_q <= rdHit;
            if (busReq.sel && busReq.rd) begin
                rdData_q <= rdHit ? rdVal : `PDR_UNMAPPED;
            end
        end
    end
    assign rdData = rdData_q;

    // Checks that tie register and pin behaviour to their causes.
    mask_reset_zero_a: assert property (@(posedge clock)
        $past(rst) |-> mask_q == '0)
        else $error("Cell mask not cleared by reset.");

    cell_load_unmasked_a: assert property (@(posedge clock)
        disable iff (rst)
        $past(wrHit && regType == `PDR_T_OUT_CELLS && portIdx == 3'h0)
        |-> ((cellOut[0] ^ $past(busReq.wdata)) & ~$past(mask_q[0])) == '0)
        else $error("Unmasked output cell bit not loaded.");

    cell_mask_block_a: assert property (@(posedge clock)
        disable iff (rst)
        $past(wrHit && regType == `PDR_T_OUT_CELLS && portIdx == 3'h1)
        |-> ((cellOut[1] ^ $past(cellNext[1])) & $past(mask_q[1])) == '0)
        else $error("Masked output cell bit was loaded.");

    latch_readback_a: assert property (@(posedge clock)
        disable iff (rst)
        wrHit && regType == `PDR_T_OUT_LATCH && portIdx == `PDR_PG
        ##1 !wrHit
        ##1 rdHit && regType == `PDR_T_OUT_LATCH && portIdx == `PDR_PG
        |=> rdData == $past(busReq.wdata, 3))
        else $error("Output latch read did not return written value.");

    pin_level_read_a: assert property (@(posedge clock)
        disable iff (rst)
        rdHit && regType == `PDR_T_PIN_LEVEL && portIdx == `PDR_PE
        |=> rdData == $past(pinLvl_q[4]))
        else $error("Pin level read mismatch.");

    chip_select_block_a: assert property (@(posedge clock)
        disable iff (rst)
        !csiOk && busReq.sel && busReq.rd |=> rdData == `PDR_UNMAPPED)
        else $error("Register read answered while deselected.");

    direction_drive_a: assert property (@(posedge clock)
        disable iff (rst)
        dir_q[6][0] && !ctrl_q[6][0] && !drive_q[6][0]
        |=> pinDrive[6].oe[0] &&
            pinDrive[6].out[0] == $past(outLatch_q[6][0]))
        else $error("Direction bit did not drive latch on pin.");

    status_matches_oe_a: assert property (@(posedge clock)
        disable iff (rst)
        rdHit && regType == `PDR_T_DRV_STATUS && portIdx == `PDR_PC
        |=> rdData == pinDrive[2].oe)
        else $error("Enable status differs from driver enable.");

    portd_narrow_a: assert property (@(posedge clock)
        disable iff (rst)
        outLatch_q[3][7:4] == 4'h0 && pinDrive[3].oe[7:4] == 4'h0)
        else $error("Port D upper bits active.");

endmodule

// file: rtl/pdr_cfg.svh
`ifndef PDR_CFG_SVH
`define PDR_CFG_SVH

`define PDR_NPORT 7
`define PDR_PA 3'h0
`define PDR_PB 3'h1
`define PDR_PC 3'h2
`define PDR_PD 3'h3
`define PDR_PE 3'h4
`define PDR_PF 3'h5
`define PDR_PG 3'h6

// Register type sits in address bits 7:4, port index in bits 2:0.
`define PDR_T_PIN_LEVEL 4'h0
`define PDR_T_OUT_LATCH 4'h1
`define PDR_T_DIRECTION 4'h2
`define PDR_T_DRIVE_SEL 4'h3
`define PDR_T_CONTROL 4'h4
`define PDR_T_OUT_CELLS 4'h5
`define PDR_T_CELL_MASK 4'h6
`define PDR_T_IN_CELLS 4'h7
`define PDR_T_DRV_STATUS 4'h8
`define PDR_T_ALT_ROUTE 4'h9
`define PDR_T_MODE 4'hA

// Mode register fields.
`define PDR_M_CSI_EN 0
`define PDR_M_BAT_IND 1
`define PDR_M_BAT_IN 2
`define PDR_M_SCAN_EN 3
`define PDR_M_DATA_PORT 4

`define PDR_REG_RESET 8'h00
`define PDR_PORTD_MASK 8'h0F
`define PDR_UNMAPPED 8'h00

`endif

// file: rtl/pdr_pkg.sv
package pdr_pkg;

    // One microcontroller bus cycle as seen at the register space.
    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdr_bus_req_t;

    // Drive of one eight-bit port.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pdr_pin_drive_t;

endpackage

// file: bench/pdr_board_model.sv
`timescale 1ns/1ns

// Board side of the ports: other parts hold the pins that are not driven.
module pdr_board_model (
    input wire pdr_pkg::pdr_pin_drive_t [6:0] pinDrive, // Device drive.
    input wire logic [6:0][7:0] extLevel, // Levels held by the board.
    output logic [6:0][7:0] pinIn // Resolved pin levels.
);
    // A driven bit shows the device value, any other shows the board level.
    // The strobe and chip-select roles of port D come from extLevel[3].
    always_comb begin
        for (int p = 0; p < 7; p++) begin
            pinIn[p] = (pinDrive[p].oe & pinDrive[p].out)
                | (~pinDrive[p].oe & extLevel[p]);
        end
    end
endmodule

// file: bench/port_data_register_path_test.sv
`timescale 1ns/1ns
`include "pdr_cfg.svh"

module port_data_register_path_test;
    logic clock;
    logic rst;
    pdr_pkg::pdr_bus_req_t busReq;
    logic [7:0] rdData;
    logic [6:0][7:0] pinIn;
    logic [6:0][7:0] extLevel;
    pdr_pkg::pdr_pin_drive_t [6:0] pinDrive;
    logic [3:0][7:0] logicOeTerm;
    logic [1:0][7:0] cellNext;
    logic [7:0] chipSel;
    logic [7:0] addrLow;
    logic [7:0] scanOut;
    logic [7:0] scanOe;
    logic vccBelowBat;
    logic [1:0][7:0] cellOut;
    logic [2:0][7:0] inCellOut;
    logic [3:0] portdDirect;
    logic [7:0] portfDirect;
    logic [1:0][7:0] fastSlew;
    logic memEnable;
    int mismatches;
    int nTests;

    pdr_port_data_regs dut_u (
        .clock(clock), .rst(rst), .busReq(busReq), .rdData(rdData),
        .pinIn(pinIn), .pinDrive(pinDrive), .logicOeTerm(logicOeTerm),
        .cellNext(cellNext), .externalChipSelects(chipSel),
        .addrLow(addrLow), .vccBelowBat(vccBelowBat), .scanOut(scanOut),
        .scanOe(scanOe), .cellOut(cellOut), .inCellOut(inCellOut),
        .portdDirect(portdDirect), .portfDirect(portfDirect),
        .fastSlew(fastSlew), .memEnable(memEnable)
    );

    pdr_board_model board_u (
        .pinDrive(pinDrive), .extLevel(extLevel), .pinIn(pinIn)
    );

    // Free-running 20 MHz clock.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [7:0] ra(input logic [3:0] t,
        input logic [2:0] p);
        return {t, 1'b0, p};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One plain write cycle; returns just after the edge that takes it.
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        busReq <= '{sel: 1'b1, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clock);
        busReq <= '0;
        #1;
    endtask

    // One plain read cycle; rdData holds, so it is compared an edge later.
    task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        busReq <= '{sel: 1'b1, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clock);
        busReq <= '0;
        @(posedge clock);
        #1;
        check(rdData, exp);
    endtask

    // Pins pass a synchroniser, so give them a few edges to land.
    task automatic settle;
        repeat (6) @(posedge clock);
    endtask

    task automatic wrapUp;
        $display("Comparisons %0d, mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge clock);
        mismatches++;
        wrapUp();
    end

    // Main sequence of register cycles and pin stimulus.
    initial begin
        rst = 1'b1;
        busReq = '0;
        extLevel = '0;
        logicOeTerm = '0;
        cellNext = '0;
        chipSel = 8'h00;
        addrLow = 8'h00;
        scanOut = 8'h00;
        scanOe = 8'h00;
        vccBelowBat = 1'b0;
        mismatches = 0;
        nTests = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rdReg(ra(`PDR_T_CELL_MASK, `PDR_PA), 8'h00);
        rdReg(ra(`PDR_T_DIRECTION, `PDR_PG), 8'h00);
        rdReg(ra(`PDR_T_DRV_STATUS, `PDR_PA), 8'h00);
        check(pinDrive[6].oe, 8'h00);
        // Every port latch keeps its own value; port D has four bits.
        for (int p = 0; p < 7; p++) begin
            wrReg(ra(`PDR_T_OUT_LATCH, 3'(p)), 8'h51 + 8'(p));
        end
        for (int p = 0; p < 7; p++) begin
            rdReg(ra(`PDR_T_OUT_LATCH, 3'(p)),
                p == 3 ? 8'h04 : 8'h51 + 8'(p));
        end
        // Pins read back live, mixing driven and undriven bits.
        extLevel[6] <= 8'h3C;
        settle();
        rdReg(ra(`PDR_T_PIN_LEVEL, `PDR_PG), 8'h3C);
        rdReg(ra(`PDR_T_PIN_LEVEL, `PDR_PE), 8'h00);
        wrReg(ra(`PDR_T_DIRECTION, `PDR_PG), 8'h0F);
        settle();
        check(pinDrive[6].oe, 8'h0F);
        rdReg(ra(`PDR_T_PIN_LEVEL, `PDR_PG), 8'h37);
        rdReg(ra(`PDR_T_OUT_LATCH, `PDR_PG), 8'h57);
        // Output cells: readable, loaded by writes unless masked.
        cellNext[0] <= 8'hC3;
        settle();
        rdReg(ra(`PDR_T_OUT_CELLS, `PDR_PA), 8'hC3);
        wrReg(ra(`PDR_T_OUT_CELLS, `PDR_PA), 8'h5A);
        check(cellOut[0], 8'h5A);
        wrReg(ra(`PDR_T_CELL_MASK, `PDR_PA), 8'hF0);
        rdReg(ra(`PDR_T_CELL_MASK, `PDR_PA), 8'hF0);
        wrReg(ra(`PDR_T_OUT_CELLS, `PDR_PA), 8'hFF);
        check(cellOut[0], 8'hCF);
        // Port B: masked low nibble keeps the logic array value.
        cellNext[1] <= 8'h3C;
        wrReg(ra(`PDR_T_CELL_MASK, `PDR_PB), 8'h0F);
        wrReg(ra(`PDR_T_OUT_CELLS, `PDR_PB), 8'hA5);
        check(cellOut[1], 8'hAC);
        // Registers missing on a port refuse writes and read zero.
        wrReg(ra(`PDR_T_CELL_MASK, `PDR_PC), 8'hFF);
        rdReg(ra(`PDR_T_CELL_MASK, `PDR_PC), 8'h00);
        rdReg(ra(`PDR_T_DRV_STATUS, `PDR_PD), 8'h00);
        rdReg(ra(`PDR_T_IN_CELLS, `PDR_PD), 8'h00);
        rdReg(8'hB0, 8'h00);
        // Logic enable term widens the driver beyond the direction bits.
        logicOeTerm[0] <= 8'hF0;
        logicOeTerm[2] <= 8'h33;
        wrReg(ra(`PDR_T_DIRECTION, `PDR_PA), 8'h0F);
        rdReg(ra(`PDR_T_DRV_STATUS, `PDR_PA), 8'hFF);
        check(pinDrive[0].oe, 8'hFF);
        rdReg(ra(`PDR_T_DRV_STATUS, `PDR_PC), 8'h33);
        check(pinDrive[2].oe, 8'h33);
        logicOeTerm <= '0;
        // Input cells follow the pins while the strobe is high.
        extLevel[3] <= 8'h01;
        extLevel[0] <= 8'h5A;
        settle();
        rdReg(ra(`PDR_T_IN_CELLS, `PDR_PA), 8'h51);
        check(inCellOut[0], 8'h51);
        check({4'h0, portdDirect}, 8'h01);
        extLevel[3] <= 8'h00;
        settle();
        extLevel[0] <= 8'hA5;
        settle();
        rdReg(ra(`PDR_T_IN_CELLS, `PDR_PA), 8'h51);
        rdReg(ra(`PDR_T_PIN_LEVEL, `PDR_PA), 8'hA1);
        // Chip-select input high shuts the register space off.
        wrReg(ra(`PDR_T_MODE, `PDR_PA), 8'h01);
        settle();
        check({7'h00, memEnable}, 8'h01);
        extLevel[3] <= 8'h04;
        settle();
        check({7'h00, memEnable}, 8'h00);
        wrReg(ra(`PDR_T_OUT_LATCH, `PDR_PG), 8'hAA);
        rdReg(ra(`PDR_T_OUT_LATCH, `PDR_PG), 8'h00);
        extLevel[3] <= 8'h00;
        settle();
        rdReg(ra(`PDR_T_OUT_LATCH, `PDR_PG), 8'h57);
        // A write followed closely by a read of the same latch.
        wrReg(ra(`PDR_T_OUT_LATCH, `PDR_PG), 8'h66);
        rdReg(ra(`PDR_T_OUT_LATCH, `PDR_PG), 8'h66);
        // Open drain releases driven ones; slew bits reach their output.
        wrReg(ra(`PDR_T_DRIVE_SEL, `PDR_PG), 8'h0F);
        wrReg(ra(`PDR_T_DRIVE_SEL, `PDR_PC), 8'hA5);
        settle();
        check(pinDrive[6].oe, 8'h09);
        check(fastSlew[0], 8'hA5);
        // Alternate routes put cells on port A and chip selects on F.
        chipSel <= 8'h3C;
        extLevel[5] <= 8'h69;
        wrReg(ra(`PDR_T_ALT_ROUTE, `PDR_PA), 8'hFF);
        wrReg(ra(`PDR_T_ALT_ROUTE, `PDR_PF), 8'hFF);
        settle();
        check(pinDrive[0].out, 8'hC3);
        check(pinDrive[5].out, 8'h3C);
        check(portfDirect, 8'h69);
        // The low address is caught while the strobe is high, then held.
        addrLow <= 8'h96;
        extLevel[3] <= 8'h01;
        settle();
        extLevel[3] <= 8'h00;
        settle();
        addrLow <= 8'h00;
        wrReg(ra(`PDR_T_CONTROL, `PDR_PG), 8'hFF);
        settle();
        check(pinDrive[6].out, 8'h96);
        // Battery indicator drives E7; battery input releases E6.
        vccBelowBat <= 1'b1;
        wrReg(ra(`PDR_T_DIRECTION, `PDR_PE), 8'hC0);
        wrReg(ra(`PDR_T_MODE, `PDR_PA), 8'h06);
        settle();
        check({5'h00, pinDrive[4].oe[7:6], pinDrive[4].out[7]},
            8'h05);
        // Boundary scan takes over all of port E.
        scanOut <= 8'h5C;
        scanOe <= 8'hF0;
        wrReg(ra(`PDR_T_MODE, `PDR_PA), 8'h08);
        settle();
        check(pinDrive[4].out, 8'h5C);
        check(pinDrive[4].oe, 8'hF0);
        // As data port, F shows the read data in the cycle after a read.
        wrReg(ra(`PDR_T_MODE, `PDR_PA), 8'h10);
        rdReg(ra(`PDR_T_OUT_LATCH, `PDR_PG), 8'h66);
        check(pinDrive[5].out, 8'h66);
        check(pinDrive[5].oe, 8'hFF);
        wrapUp();
    end
endmodule
